// file: verilog/branch_decode_pkg.sv
// Opcodes, special register addresses, reset values and carrier types for the branch and bit decoder
package branch_decode_pkg;

  // Carry boolean operations
  localparam logic [7:0] OP_AND_BIT_CARRY     = 8'h82;
  localparam logic [7:0] OP_AND_NBIT_CARRY    = 8'hB0;
  localparam logic [7:0] OP_OR_BIT_CARRY      = 8'h72;
  localparam logic [7:0] OP_OR_NBIT_CARRY     = 8'hA0;
  localparam logic [7:0] OP_MOVE_BIT_TO_CARRY = 8'hA2;
  localparam logic [7:0] OP_MOVE_CARRY_TO_BIT = 8'h92;
  // Conditional jumps
  localparam logic [7:0] OP_JUMP_IF_CARRY_SET   = 8'h40;
  localparam logic [7:0] OP_JUMP_IF_CARRY_CLEAR = 8'h50;
  localparam logic [7:0] OP_JUMP_IF_BIT_SET     = 8'h20;
  localparam logic [7:0] OP_JUMP_IF_BIT_CLEAR   = 8'h30;
  localparam logic [7:0] OP_JUMP_AND_CLEAR_BIT  = 8'h10;
  localparam logic [7:0] OP_JUMP_IF_ACC_ZERO    = 8'h60;
  localparam logic [7:0] OP_JUMP_IF_ACC_NONZERO = 8'h70;
  localparam logic [7:0] OP_COMPARE_ACC_DIRECT  = 8'hB5;
  localparam logic [7:0] OP_COMPARE_ACC_IMM     = 8'hB4;
  localparam logic [7:0] OP_COMPARE_INDIRECT    = 8'hB6;
  localparam logic [7:0] OP_COMPARE_BANK_REG    = 8'hB8;
  localparam logic [7:0] OP_DECREMENT_BANK_REG  = 8'hD8;
  localparam logic [7:0] OP_DECREMENT_DIRECT    = 8'hD5;
  // Unconditional branches and calls, the pointer load and the no-operations; the page forms match on the low five bits
  localparam logic [4:0] OP_ABSOLUTE_CALL_LOW = 5'h11;
  localparam logic [4:0] OP_ABSOLUTE_JUMP_LOW = 5'h01;
  localparam logic [7:0] OP_LONG_CALL         = 8'h12;
  localparam logic [7:0] OP_LONG_JUMP         = 8'h02;
  localparam logic [7:0] OP_SHORT_JUMP        = 8'h80;
  localparam logic [7:0] OP_INDIRECT_JUMP     = 8'h73;
  localparam logic [7:0] OP_LOAD_POINTER_IMM  = 8'h90;
  localparam logic [7:0] OP_NO_OPERATION      = 8'h00;
  localparam logic [7:0] OP_UNUSED            = 8'hA5;

  // Special register space
  localparam logic [7:0] ADDR_POINTER_LOW  = 8'h82;
  localparam logic [7:0] ADDR_POINTER_HIGH = 8'h83;
  localparam logic [7:0] RST_POINTER_LOW   = 8'h00;
  localparam logic [7:0] RST_POINTER_HIGH  = 8'h00;
  localparam logic [7:0] RST_CARRY_BYTE    = 8'h00;
  localparam logic [15:0] RST_PROG_COUNTER = 16'h0000;
  localparam logic [7:0] BIT_AREA_BASE     = 8'h20;
  localparam logic [7:0] FULL_MASK         = 8'hFF;

  typedef enum logic [1:0] {
    CY1 = 2'b00,
    CY2 = 2'b01,
    CY3 = 2'b11,
    CY4 = 2'b10
  } cycle_t;

  // One request toward internal data RAM or the special register space
  typedef struct packed {
    logic [7:0] addr;
    logic       special;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } data_req_t;

  typedef struct packed {
    cycle_t     cyc;
    logic [15:0] pc;
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [7:0]  val;
    logic [7:0]  data_pointer_low_byte;
    logic [7:0]  data_pointer_high_byte;
    logic        carry;
    logic        pend_v;
    logic [7:0]  pend_op;
    logic [2:0]  pend_idx;
    data_req_t   req;
    logic        start;
    logic        foreign;
    logic        sp_adv;
    logic [7:0]  special_rdata;
  } core_state_t;

endpackage

// file: verilog/operand_locator.sv
// Maps a bit address and a bank register number onto data memory byte addresses
`timescale 1ns/1ps
`default_nettype none
module operand_locator
  import branch_decode_pkg::*;
(
  input  wire logic [7:0] bit_addr,
  input  wire logic [1:0] bank_sel,
  input  wire logic [2:0] reg_sel,
  output logic      [7:0] byte_addr,
  output logic            special,
  output logic      [7:0] mask,
  output logic      [7:0] reg_addr
);

  always_comb begin
    if (bit_addr[7]) begin
      byte_addr = {bit_addr[7:3], 3'b000}; // [RL13]
      special   = 1'b1;
    end else begin
      byte_addr = BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
      special   = 1'b0;
    end
    mask     = 8'h01 << bit_addr[2:0];
    reg_addr = {3'b000, bank_sel, reg_sel}; // [RL10] [RL21]
  end

endmodule // operand_locator
`default_nettype wire

// file: verilog/branch_decode.sv
// Decode and execution timing for carry bit operations, branches, calls and the data pointer
//
// Behaviour
// RL1 - Carry and/or/move bit operations: two bytes, two cycles.
// RL2 - Jump on carry set or clear: two bytes, two or three cycles.
// RL3 - Jump on direct bit set or clear: three bytes, three or four cycles.
// RL4 - Jump-and-clear branches on a set bit and clears it; three or four cycles.
// RL5 - Long call: three bytes, four cycles.
// RL6 - Jump on accumulator zero or nonzero: two bytes, two or three cycles.
// RL7 - Compare accumulator with direct or immediate, branch if unequal; three or four.
// RL8 - Decrement bank register, branch if nonzero; two or three cycles.
// RL9 - Decrement direct byte, branch if nonzero; three or four cycles.
// RL10 - Register operands are registers 0 to 7 of the selected bank.
// RL11 - Indirect operands use register 0 or 1 as data address.
// RL12 - Relative offset is signed 8-bit, added to next instruction address.
// RL13 - Direct addresses below 0x80 are RAM, 0x80 and above special registers.
// RL14 - Page call and jump target stays in the 2 kB page.
// RL15 - Long call and jump take a full 16-bit target.
// RL16 - The unused opcode behaves as a no-operation.
// RL17 - Immediates are 8-bit, except the 16-bit data pointer load.
// RL18 - Software writes reserved bits with their documented value.
// RL19 - Data pointer low byte at 0x82, read/write, resets to zero.
// RL20 - Data pointer high byte at 0x83, read/write, resets to zero.
// RL21 - Bank select 00 picks lowest bank, 11 the highest.
// RL22 - Indirect jump goes to accumulator plus data pointer.
`timescale 1ns/1ps
`default_nettype none
module branch_decode
  import branch_decode_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  output logic      [15:0] CODE_ADDR,
  input  wire logic [7:0]  CODE_DATA,
  output data_req_t        DATA_REQ,
  input  wire logic [7:0]  DATA_RDATA,
  input  wire logic [7:0]  ACC,
  input  wire logic [1:0]  BANK_SEL,
  input  wire logic [7:0]  STACK_PTR,
  output logic             SP_ADV,
  output logic             CARRY,
  output logic      [15:0] DATA_POINTER,
  output logic             INSTR_START,
  output logic             FOREIGN_OP,
  input  wire logic [7:0]  SPECIAL_ADDR,
  input  wire logic        SPECIAL_WR,
  input  wire logic [7:0]  SPECIAL_WDATA,
  output logic      [7:0]  SPECIAL_RDATA
);

  core_state_t s_r;
  core_state_t s_nxt;
  logic [7:0]  rdv;
  logic [7:0]  loc_in;
  logic [7:0]  loc_byte;
  logic        loc_special;
  logic [7:0]  loc_mask;
  logic [7:0]  loc_reg;
  logic [2:0]  reg_sel;
  logic [7:0]  rel_byte;
  logic [15:0] rel_tgt;

  function automatic logic is_known(input logic [7:0] op);
    is_known = (op == OP_AND_BIT_CARRY) || (op == OP_AND_NBIT_CARRY) || (op == OP_OR_BIT_CARRY) ||
               (op == OP_OR_NBIT_CARRY) || (op == OP_MOVE_BIT_TO_CARRY) || (op == OP_MOVE_CARRY_TO_BIT) ||
               (op == OP_JUMP_IF_CARRY_SET) || (op == OP_JUMP_IF_CARRY_CLEAR) || (op == OP_JUMP_IF_BIT_SET) ||
               (op == OP_JUMP_IF_BIT_CLEAR) || (op == OP_JUMP_AND_CLEAR_BIT) || (op == OP_JUMP_IF_ACC_ZERO) ||
               (op == OP_JUMP_IF_ACC_NONZERO) || (op == OP_COMPARE_ACC_DIRECT) || (op == OP_COMPARE_ACC_IMM) ||
               (op[7:1] == OP_COMPARE_INDIRECT[7:1]) || (op[7:3] == OP_COMPARE_BANK_REG[7:3]) ||
               (op[7:3] == OP_DECREMENT_BANK_REG[7:3]) || (op == OP_DECREMENT_DIRECT) ||
               (op[4:0] == OP_ABSOLUTE_CALL_LOW) || (op[4:0] == OP_ABSOLUTE_JUMP_LOW) ||
               (op == OP_LONG_CALL) || (op == OP_LONG_JUMP) || (op == OP_SHORT_JUMP) ||
               (op == OP_INDIRECT_JUMP) || (op == OP_LOAD_POINTER_IMM);
  endfunction

  function automatic logic is_carry_bit_op(input logic [7:0] op);
    is_carry_bit_op = (op == OP_AND_BIT_CARRY) || (op == OP_AND_NBIT_CARRY) || (op == OP_OR_BIT_CARRY) ||
                      (op == OP_OR_NBIT_CARRY) || (op == OP_MOVE_BIT_TO_CARRY);
  endfunction

  function automatic logic is_short_rel(input logic [7:0] op);
    is_short_rel = (op == OP_JUMP_IF_CARRY_SET) || (op == OP_JUMP_IF_CARRY_CLEAR) ||
                   (op == OP_JUMP_IF_ACC_ZERO) || (op == OP_JUMP_IF_ACC_NONZERO) ||
                   (op == OP_SHORT_JUMP) || (op[7:3] == OP_DECREMENT_BANK_REG[7:3]);
  endfunction

  // Bit or register operand location
  assign loc_in  = (s_r.cyc == CY2) ? CODE_DATA : s_r.b2;
  assign reg_sel = (CODE_DATA[7:1] == OP_COMPARE_INDIRECT[7:1]) ? {2'b00, CODE_DATA[0]} : CODE_DATA[2:0]; // [RL11]

  operand_locator u_locator (
    .bit_addr  (loc_in),
    .bank_sel  (BANK_SEL),
    .reg_sel   (reg_sel),
    .byte_addr (loc_byte),
    .special   (loc_special),
    .mask      (loc_mask),
    .reg_addr  (loc_reg)
  );

  // Read data of the previous request; the data pointer answers its own addresses
  always_comb begin
    if (s_r.req.special && s_r.req.addr == ADDR_POINTER_LOW) begin
      rdv = s_r.data_pointer_low_byte;
    end else if (s_r.req.special && s_r.req.addr == ADDR_POINTER_HIGH) begin
      rdv = s_r.data_pointer_high_byte;
    end else begin
      rdv = DATA_RDATA;
    end
  end

  assign rel_byte = (s_r.cyc == CY4) ? s_r.b3 : s_r.b2;
  assign rel_tgt  = s_r.pc + {{8{rel_byte[7]}}, rel_byte}; // [RL12]

  always_comb begin
    logic [15:0] ret;
    logic [7:0]  dec;
    logic [7:0]  lhs;
    logic [7:0]  rhs;
    logic        bitv;
    logic        taken;
    ret   = 16'h0000;
    dec   = 8'h00;
    lhs   = 8'h00;
    rhs   = 8'h00;
    bitv  = 1'b0;
    taken = 1'b0;
    s_nxt = s_r;
    s_nxt.req.rd  = 1'b0;
    s_nxt.req.wr  = 1'b0;
    s_nxt.start   = 1'b0;
    s_nxt.foreign = 1'b0;
    s_nxt.sp_adv  = 1'b0;
    // Register port: pointer bytes answer, other addresses read zero
    if (SPECIAL_ADDR == ADDR_POINTER_LOW) begin
      s_nxt.special_rdata = s_r.data_pointer_low_byte; // [RL19]
    end else if (SPECIAL_ADDR == ADDR_POINTER_HIGH) begin
      s_nxt.special_rdata = s_r.data_pointer_high_byte; // [RL20]
    end else begin
      s_nxt.special_rdata = 8'h00;
    end
    if (SPECIAL_WR && SPECIAL_ADDR == ADDR_POINTER_LOW) begin
      s_nxt.data_pointer_low_byte = SPECIAL_WDATA; // [RL19]
    end
    if (SPECIAL_WR && SPECIAL_ADDR == ADDR_POINTER_HIGH) begin
      s_nxt.data_pointer_high_byte = SPECIAL_WDATA; // [RL20]
    end
    // Finish a carry bit operation while the next opcode is fetched
    if (s_r.pend_v) begin
      s_nxt.pend_v = 1'b0;
      bitv = rdv[s_r.pend_idx];
      if (s_r.pend_op == OP_AND_BIT_CARRY) begin
        s_nxt.carry = s_r.carry & bitv; // [RL1]
      end else if (s_r.pend_op == OP_AND_NBIT_CARRY) begin
        s_nxt.carry = s_r.carry & ~bitv;
      end else if (s_r.pend_op == OP_OR_BIT_CARRY) begin
        s_nxt.carry = s_r.carry | bitv;
      end else if (s_r.pend_op == OP_OR_NBIT_CARRY) begin
        s_nxt.carry = s_r.carry | ~bitv;
      end else begin
        s_nxt.carry = bitv;
      end
    end
    unique case (s_r.cyc)
      CY1: begin
        s_nxt.op    = CODE_DATA;
        s_nxt.pc    = s_r.pc + 16'h0001;
        s_nxt.start = 1'b1;
        s_nxt.cyc   = CY2;
        if (CODE_DATA == OP_NO_OPERATION || CODE_DATA == OP_UNUSED) begin
          s_nxt.cyc = CY1; // [RL16]
        end else if (!is_known(CODE_DATA)) begin
          s_nxt.cyc     = CY1;
          s_nxt.foreign = 1'b1;
        end else if (CODE_DATA[7:3] == OP_DECREMENT_BANK_REG[7:3] || CODE_DATA[7:3] == OP_COMPARE_BANK_REG[7:3] ||
                     CODE_DATA[7:1] == OP_COMPARE_INDIRECT[7:1]) begin
          s_nxt.req = '{addr: loc_reg, special: 1'b0, rd: 1'b1, wr: 1'b0, wdata: 8'h00, wmask: 8'h00}; // [RL10]
        end else if (CODE_DATA[4:0] == OP_ABSOLUTE_CALL_LOW || CODE_DATA == OP_LONG_CALL) begin
          ret = (CODE_DATA == OP_LONG_CALL) ? s_r.pc + 16'h0003 : s_r.pc + 16'h0002;
          s_nxt.req = '{addr: STACK_PTR + 8'h01, special: 1'b0, rd: 1'b0, wr: 1'b1, wdata: ret[7:0],
                        wmask: FULL_MASK};
        end
      end
      CY2: begin
        s_nxt.b2  = CODE_DATA;
        s_nxt.pc  = s_r.pc + 16'h0001;
        s_nxt.cyc = CY3;
        if (is_carry_bit_op(s_r.op)) begin
          s_nxt.req = '{addr: loc_byte, special: loc_special, rd: 1'b1, wr: 1'b0, wdata: 8'h00, wmask: 8'h00};
          s_nxt.pend_v   = 1'b1;
          s_nxt.pend_op  = s_r.op;
          s_nxt.pend_idx = CODE_DATA[2:0];
          s_nxt.cyc      = CY1; // [RL1]
        end else if (s_r.op == OP_MOVE_CARRY_TO_BIT) begin
          s_nxt.req = '{addr: loc_byte, special: loc_special, rd: 1'b0, wr: 1'b1, wdata: {8{s_r.carry}},
                        wmask: loc_mask};
          s_nxt.cyc = CY1; // [RL1]
        end else if (s_r.op == OP_JUMP_IF_CARRY_SET || s_r.op == OP_JUMP_IF_CARRY_CLEAR) begin
          taken = (s_r.op == OP_JUMP_IF_CARRY_SET) ? s_r.carry : ~s_r.carry;
          s_nxt.cyc = taken ? CY3 : CY1; // [RL2]
        end else if (s_r.op == OP_JUMP_IF_ACC_ZERO || s_r.op == OP_JUMP_IF_ACC_NONZERO) begin
          taken = (s_r.op == OP_JUMP_IF_ACC_ZERO) ? (ACC == 8'h00) : (ACC != 8'h00);
          s_nxt.cyc = taken ? CY3 : CY1; // [RL6]
        end else if (s_r.op[7:3] == OP_DECREMENT_BANK_REG[7:3]) begin
          dec = rdv - 8'h01;
          s_nxt.req = '{addr: s_r.req.addr, special: 1'b0, rd: 1'b0, wr: 1'b1, wdata: dec, wmask: FULL_MASK};
          s_nxt.cyc = (dec != 8'h00) ? CY3 : CY1; // [RL8]
        end else if (s_r.op == OP_INDIRECT_JUMP) begin
          s_nxt.pc = s_r.pc;
          s_nxt.b2 = s_r.b2;
        end else if (s_r.op[4:0] == OP_ABSOLUTE_CALL_LOW || s_r.op == OP_LONG_CALL) begin
          ret = (s_r.op == OP_LONG_CALL) ? s_r.pc + 16'h0002 : s_r.pc + 16'h0001;
          s_nxt.req = '{addr: STACK_PTR + 8'h02, special: 1'b0, rd: 1'b0, wr: 1'b1, wdata: ret[15:8],
                        wmask: FULL_MASK};
          s_nxt.sp_adv = 1'b1;
        end else if (s_r.op == OP_JUMP_IF_BIT_SET || s_r.op == OP_JUMP_IF_BIT_CLEAR ||
                     s_r.op == OP_JUMP_AND_CLEAR_BIT) begin
          s_nxt.req = '{addr: loc_byte, special: loc_special, rd: 1'b1, wr: 1'b0, wdata: 8'h00, wmask: 8'h00};
        end else if (s_r.op == OP_DECREMENT_DIRECT || s_r.op == OP_COMPARE_ACC_DIRECT) begin
          s_nxt.req = '{addr: CODE_DATA, special: CODE_DATA[7], rd: 1'b1, wr: 1'b0, wdata: 8'h00,
                        wmask: 8'h00}; // [RL13]
        end else if (s_r.op[7:1] == OP_COMPARE_INDIRECT[7:1]) begin
          s_nxt.req = '{addr: rdv, special: 1'b0, rd: 1'b1, wr: 1'b0, wdata: 8'h00, wmask: 8'h00}; // [RL11]
        end else if (s_r.op[7:3] == OP_COMPARE_BANK_REG[7:3]) begin
          s_nxt.val = rdv;
        end
      end
      CY3: begin
        if (is_short_rel(s_r.op)) begin
          s_nxt.pc  = rel_tgt; // [RL12]
          s_nxt.cyc = CY1;
        end else if (s_r.op[4:0] == OP_ABSOLUTE_CALL_LOW || s_r.op[4:0] == OP_ABSOLUTE_JUMP_LOW) begin
          s_nxt.pc  = {s_r.pc[15:11], s_r.op[7:5], s_r.b2}; // [RL14]
          s_nxt.cyc = CY1;
        end else if (s_r.op == OP_INDIRECT_JUMP) begin
          s_nxt.pc  = {s_r.data_pointer_high_byte, s_r.data_pointer_low_byte} + {8'h00, ACC}; // [RL22]
          s_nxt.cyc = CY1;
        end else begin
          s_nxt.b3 = CODE_DATA;
          s_nxt.pc = s_r.pc + 16'h0001;
          if (s_r.op == OP_JUMP_IF_BIT_SET || s_r.op == OP_JUMP_IF_BIT_CLEAR ||
              s_r.op == OP_JUMP_AND_CLEAR_BIT) begin
            bitv  = rdv[s_r.b2[2:0]];
            taken = (s_r.op == OP_JUMP_IF_BIT_CLEAR) ? ~bitv : bitv; // [RL3]
            if (s_r.op == OP_JUMP_AND_CLEAR_BIT && bitv) begin
              s_nxt.req = '{addr: s_r.req.addr, special: s_r.req.special, rd: 1'b0, wr: 1'b1, wdata: 8'h00,
                            wmask: loc_mask}; // [RL4]
            end
          end else if (s_r.op == OP_DECREMENT_DIRECT) begin
            dec   = rdv - 8'h01;
            taken = (dec != 8'h00); // [RL9]
            s_nxt.req = '{addr: s_r.req.addr, special: s_r.req.special, rd: 1'b0, wr: 1'b1, wdata: dec,
                          wmask: FULL_MASK};
          end else if (s_r.op == OP_LONG_JUMP || s_r.op == OP_LONG_CALL) begin
            taken = 1'b1; // [RL5]
          end else if (s_r.op == OP_LOAD_POINTER_IMM) begin
            s_nxt.data_pointer_high_byte = s_r.b2; // [RL17]
            s_nxt.data_pointer_low_byte = CODE_DATA;
          end else begin
            lhs = (s_r.op[7:3] == OP_COMPARE_BANK_REG[7:3]) ? s_r.val :
                  (s_r.op[7:1] == OP_COMPARE_INDIRECT[7:1]) ? rdv : ACC;
            rhs = (s_r.op == OP_COMPARE_ACC_DIRECT) ? rdv : s_r.b2; // [RL17]
            s_nxt.carry = (lhs < rhs);
            taken = (lhs != rhs); // [RL7]
          end
          s_nxt.cyc = taken ? CY4 : CY1;
        end
      end
      CY4: begin
        if (s_r.op == OP_LONG_JUMP || s_r.op == OP_LONG_CALL) begin
          s_nxt.pc = {s_r.b2, s_r.b3}; // [RL15]
        end else begin
          s_nxt.pc = rel_tgt; // [RL12]
        end
        s_nxt.cyc = CY1;
      end
    endcase
    // Data writes to the pointer bytes land in the pointer, not on the port
    if (s_nxt.req.wr && s_nxt.req.special && s_nxt.req.addr == ADDR_POINTER_LOW) begin
      s_nxt.data_pointer_low_byte    = s_nxt.req.wdata; // [RL19]
      s_nxt.req.wr = 1'b0;
    end else if (s_nxt.req.wr && s_nxt.req.special && s_nxt.req.addr == ADDR_POINTER_HIGH) begin
      s_nxt.data_pointer_high_byte    = s_nxt.req.wdata; // [RL20]
      s_nxt.req.wr = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      s_r       <= '0;
      s_r.cyc   <= CY1;
      s_r.pc    <= RST_PROG_COUNTER;
      s_r.data_pointer_low_byte   <= RST_POINTER_LOW;
      s_r.data_pointer_high_byte   <= RST_POINTER_HIGH;
      s_r.carry <= RST_CARRY_BYTE[0];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign CODE_ADDR     = s_r.pc;
  assign DATA_REQ      = s_r.req;
  assign SP_ADV        = s_r.sp_adv;
  assign CARRY         = s_r.carry;
  assign DATA_POINTER  = {s_r.data_pointer_high_byte, s_r.data_pointer_low_byte};
  assign INSTR_START   = s_r.start;
  assign FOREIGN_OP    = s_r.foreign;
  assign SPECIAL_RDATA = s_r.special_rdata;

  AST_BIT_CARRY_TWO: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL1]
    s_r.start && is_carry_bit_op(s_r.op) |=> !s_r.start ##1 s_r.start)
    else $error("carry bit operation not two cycles");
  AST_CARRY_JUMP_TAKEN: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL2]
    s_r.start && s_r.op == OP_JUMP_IF_CARRY_SET && s_r.carry |=> (!s_r.start)[*2] ##1 s_r.start)
    else $error("taken carry jump not three cycles");
  AST_BIT_JUMP_NOT_TAKEN: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL3]
    s_r.cyc == CY3 && s_r.op == OP_JUMP_IF_BIT_SET && !rdv[s_r.b2[2:0]] |=> s_r.cyc == CY1 ##1 s_r.start)
    else $error("untaken bit jump not three cycles");
  AST_CLEAR_BIT_WRITE: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL4]
    s_r.cyc == CY3 && s_r.op == OP_JUMP_AND_CLEAR_BIT && rdv[s_r.b2[2:0]] && !s_r.req.special
    |=> s_r.req.wr && s_r.req.wdata == 8'h00 && s_r.req.addr == $past(s_r.req.addr) && s_r.cyc == CY4)
    else $error("jump and clear did not clear its bit");
  AST_LONG_CALL_FOUR: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL5]
    s_r.start && s_r.op == OP_LONG_CALL |=> (!s_r.start)[*3] ##1 s_r.start)
    else $error("long call not four cycles");
  AST_DECREMENT_REG: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL8]
    s_r.cyc == CY2 && s_r.op[7:3] == OP_DECREMENT_BANK_REG[7:3] && rdv == 8'h01
    |=> s_r.req.wr && s_r.req.wdata == 8'h00 ##1 s_r.start)
    else $error("decrement to zero branched or skipped write");
  AST_BANK_ADDRESS: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL10]
    s_r.cyc == CY1 && CODE_DATA[7:3] == OP_DECREMENT_BANK_REG[7:3]
    |=> s_r.req.rd && s_r.req.addr == {3'b000, $past(BANK_SEL), $past(CODE_DATA[2:0])})
    else $error("bank register address wrong");
  AST_SHORT_JUMP_TARGET: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL12]
    s_r.cyc == CY3 && s_r.op == OP_SHORT_JUMP |=> s_r.pc == $past(rel_tgt) && s_r.cyc == CY1)
    else $error("short jump target wrong");
  AST_PAGE_JUMP: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL14]
    s_r.cyc == CY3 && s_r.op[4:0] == OP_ABSOLUTE_JUMP_LOW
    |=> s_r.pc == {$past(s_r.pc[15:11]), $past(s_r.op[7:5]), $past(s_r.b2)})
    else $error("page jump left its page");
  AST_UNUSED_OPCODE: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL16]
    s_r.cyc == CY1 && CODE_DATA == OP_UNUSED |=> s_r.start && !s_r.req.wr && !s_r.req.rd && s_r.cyc == CY1)
    else $error("unused opcode did more than nothing");
  AST_POINTER_RESET: assert property (@(posedge REF_CLK) // [RL19]
    !NRST |=> DATA_POINTER == 16'h0000)
    else $error("data pointer not zero after reset");
  AST_INDIRECT_JUMP: assert property (@(posedge REF_CLK) disable iff (!NRST) // [RL22]
    s_r.cyc == CY3 && s_r.op == OP_INDIRECT_JUMP |=> s_r.pc == $past(DATA_POINTER) + {8'h00, $past(ACC)})
    else $error("indirect jump target wrong");

  COV_TAKEN_COMPARE: cover property (@(posedge REF_CLK) disable iff (!NRST)
    s_r.cyc == CY4 && s_r.op == OP_COMPARE_ACC_IMM);
  COV_DECREMENT_DIRECT_LOOP: cover property (@(posedge REF_CLK) disable iff (!NRST)
    s_r.cyc == CY4 && s_r.op == OP_DECREMENT_DIRECT);
  COV_LONG_CALL: cover property (@(posedge REF_CLK) disable iff (!NRST)
    s_r.sp_adv && s_r.op == OP_LONG_CALL);
  COV_POINTER_WRITE: cover property (@(posedge REF_CLK) disable iff (!NRST)
    SPECIAL_WR && SPECIAL_ADDR == ADDR_POINTER_HIGH);

endmodule // branch_decode
`default_nettype wire

// file: testbench/code_data_memory.sv
// Program memory and internal data RAM model facing the decoder
`timescale 1ns/1ps
`default_nettype none
module code_data_memory
  import branch_decode_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic [15:0] CODE_ADDR,
  output logic      [7:0]  CODE_DATA,
  input  wire data_req_t   DATA_REQ,
  output logic      [7:0]  DATA_RDATA
);
  logic [7:0] rom [0:255];
  logic [7:0] ram [0:127];
  assign CODE_DATA = rom[CODE_ADDR[7:0]];
  // Idle read port shows the inverse, so stale data never passes for valid
  assign DATA_RDATA = DATA_REQ.rd ? ram[DATA_REQ.addr[6:0]] : ~ram[DATA_REQ.addr[6:0]];
  always @(posedge REF_CLK) begin
    if (DATA_REQ.wr && !DATA_REQ.special) begin
      ram[DATA_REQ.addr[6:0]] <= (ram[DATA_REQ.addr[6:0]] & ~DATA_REQ.wmask) | (DATA_REQ.wdata & DATA_REQ.wmask);
    end
  end
endmodule  // code_data_memory
`default_nettype wire

// file: testbench/branch_decode_test.sv
// Self-checking bench running a short program and the pointer register port
`timescale 1ns/1ps
`default_nettype none
module branch_decode_test;
  import branch_decode_pkg::*;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [15:0] code_addr, data_pointer;
  logic [7:0] code_data, data_rdata, special_rdata;
  logic [7:0] special_addr = 8'h00, special_wdata = 8'h00;
  logic special_wr = 1'b0;
  logic instr_start;
  data_req_t data_req;
  int fails = 0, tests_run = 0, gap = 0, cycles = 0;
  int gaps [$];
  int exp_gap [18] = '{1, 1, 2, 2, 3, 2, 3, 4, 4, 3, 3, 4, 3, 4, 4, 3, 3, 3};
  // Second block at 0x20: compares, bit jumps, decrements, indirect compare, page jump, then a loop
  logic [7:0] prog2 [28] = '{8'hB4, 8'h05, 8'h02, 8'h00, 8'h00, 8'h40, 8'h00, 8'h20, 8'h20, 8'h00,
                             8'h10, 8'h21, 8'h00, 8'hD8, 8'h02, 8'h00, 8'h00, 8'hD5, 8'h10, 8'h00,
                             8'hB6, 8'h03, 8'h00, 8'h01, 8'h3A, 8'h00, 8'h80, 8'hFE};
  logic [7:0] prog [18] = '{8'h00, 8'hA5, 8'h92, 8'h20, 8'h40, 8'h05, 8'h60, 8'h02, 8'h00,
                            8'h00, 8'h70, 8'h02, 8'h90, 8'h12, 8'h34, 8'h12, 8'h00, 8'h20};
  always #50 REF_CLK = ~REF_CLK;
  branch_decode dut (.REF_CLK(REF_CLK), .NRST(NRST), .CODE_ADDR(code_addr), .CODE_DATA(code_data),
    .DATA_REQ(data_req), .DATA_RDATA(data_rdata), .ACC(8'h00), .BANK_SEL(2'b00), .STACK_PTR(8'h07),
    .SP_ADV(), .CARRY(), .DATA_POINTER(data_pointer), .INSTR_START(instr_start), .FOREIGN_OP(),
    .SPECIAL_ADDR(special_addr), .SPECIAL_WR(special_wr), .SPECIAL_WDATA(special_wdata),
    .SPECIAL_RDATA(special_rdata));
  code_data_memory mem (.REF_CLK(REF_CLK), .CODE_ADDR(code_addr), .CODE_DATA(code_data),
    .DATA_REQ(data_req), .DATA_RDATA(data_rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic sp_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge REF_CLK) special_addr = a;
    @(negedge REF_CLK) check({8'h00, special_rdata}, {8'h00, exp});
  endtask
  task automatic sp_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge REF_CLK) begin
      special_addr = a;
      special_wdata = d;
      special_wr = 1'b1;
    end
    @(negedge REF_CLK) special_wr = 1'b0;
  endtask
  // Cycles between successive instruction starts
  always @(negedge REF_CLK) begin
    cycles++;
    if (cycles > 2000) begin
      fails++;
      test_done();
    end
    if (NRST) begin
      gap++;
      if (instr_start === 1'b1) begin
        gaps.push_back(gap);
        gap = 0;
      end
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) mem.rom[i] = 8'h00;
    for (int i = 0; i < 128; i++) mem.ram[i] = 8'hFF;
    for (int i = 0; i < 18; i++) mem.rom[i] = prog[i];
    for (int i = 0; i < 28; i++) mem.rom[32 + i] = prog2[i];
    repeat (5) @(negedge REF_CLK);
    NRST = 1'b1;
    sp_rd(ADDR_POINTER_LOW, 8'h00);
    sp_rd(ADDR_POINTER_HIGH, 8'h00);
    repeat (80) @(negedge REF_CLK);
    for (int i = 0; i < 18; i++) check(16'(gaps[i + 1]), 16'(exp_gap[i]));
    check({8'h00, mem.ram[36]}, 16'h00FC);
    check({8'h00, mem.ram[0]}, 16'h00FE);
    check({8'h00, mem.ram[16]}, 16'h00FE);
    check({mem.ram[9], mem.ram[8]}, 16'h0012);
    check(data_pointer, 16'h1234);
    sp_wr(ADDR_POINTER_LOW, 8'hA5);
    check(data_pointer, 16'h12A5);
    sp_rd(ADDR_POINTER_LOW, 8'hA5);
    sp_rd(ADDR_POINTER_HIGH, 8'h12);
    sp_rd(8'h81, 8'h00);
    test_done();
  end
endmodule  // branch_decode_test
`default_nettype wire
